// File: design/omc_pkg.sv
// omc_pkg: register map, field layout and state codes of the mode control
// assumes: an 8-bit register placed in the low byte of a 32-bit bus word
package omc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int OMC_ADDR_W = 8;
	localparam int OMC_DATA_W = 32;
	localparam int OMC_BE_W = 4;
	localparam int OMC_REG_W = 8;
	// register index, byte address is four times it
	localparam logic [OMC_ADDR_W-1:0] OMC_CTL_INDEX = 8'h0A;
	localparam logic [OMC_ADDR_W-1:0] OMC_CTL_ADDR = 8'h28;
	localparam logic [OMC_REG_W-1:0] OMC_CTL_RESET = 8'h00;
	localparam logic [OMC_DATA_W-1:0] OMC_READ_ZERO = 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// field layout
	localparam int OMC_MODE_HI = 7;
	localparam int OMC_MODE_LO = 6;
	localparam int OMC_SKIP_HI = 5;
	localparam int OMC_SKIP_LO = 3;
	localparam int OMC_CHOP_BIT = 2;
	localparam int OMC_WAKE_BIT = 1;
	localparam int OMC_RUN_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// mode codes and skip count
	localparam logic [1:0] OMC_MODE_NORMAL1 = 2'h0;
	localparam logic [1:0] OMC_MODE_NORMAL2 = 2'h1;
	localparam logic [1:0] OMC_MODE_STANDBY1 = 2'h2;
	localparam logic [1:0] OMC_MODE_STANDBY2 = 2'h3;
	localparam int OMC_CNT_W = 4;
	localparam logic [OMC_CNT_W-1:0] OMC_SKIP_BASE = 4'h3;
	localparam logic [OMC_CNT_W-1:0] OMC_CNT_ZERO = 4'h0;
	localparam logic [OMC_CNT_W-1:0] OMC_CNT_ONE = 4'h1;

	////////////////////////////////////////////////////////////////////////
	// operating states, one-hot
	typedef enum logic [4:0] {
		OMC_ST_STOP = 5'h01,
		OMC_ST_NORMAL1 = 5'h02,
		OMC_ST_NORMAL2 = 5'h04,
		OMC_ST_STANDBY1 = 5'h08,
		OMC_ST_STANDBY2 = 5'h10
	} omc_state_t;

endpackage : omc_pkg

// File: design/omc_skip_counter.sv
// omc_skip_counter: counts data cycles after a restart up to a target
// assumes: data_cycle is a one-cycle pulse per finished data cycle
`timescale 1ns/1ps
module omc_skip_counter
	import omc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic restart,
	input wire logic data_cycle,
	input wire logic [omc_pkg::OMC_CNT_W-1:0] target,
	output logic done
);
	import omc_pkg::*;

	logic [OMC_CNT_W-1:0] count;
	logic [OMC_CNT_W-1:0] next_count;
	wire reached;
	wire bump;

	// count saturates once the target is reached
	assign reached = (count >= target);
	assign bump = data_cycle && !reached;
	assign next_count = restart ? OMC_CNT_ZERO :
		(bump ? count + OMC_CNT_ONE : count);

	// counter and done flag
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count <= OMC_CNT_ZERO;
			done <= 1'b0;
		end else begin
			count <= next_count;
			done <= !restart && (next_count >= target);
		end
	end

endmodule : omc_skip_counter

// File: design/omc_mode_ctrl.sv
// omc_mode_ctrl: mode control register with avalon-mm slave and mode logic
// assumes: one 50 mhz clock, data_cycle and chopper clock synchronous to it
`timescale 1ns/1ps
// Functional notes
// - top two bits pick normal 1, normal 2, standby 1 or standby 2.
// - mode field resets to 00, the first normal mode.
// - standby skips field code plus three data cycles before threshold compare.
// - skip field resets to zero, meaning three skipped cycles.
// - bit two gates the chopper clock onto its output pin, clear at reset.
// - bit zero clear holds the stop state, set allows the selected mode.
// - bit one enables the pin flagging a standby to normal transition.
module omc_mode_ctrl
	import omc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [omc_pkg::OMC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [omc_pkg::OMC_DATA_W-1:0] avs_writedata,
	input wire logic [omc_pkg::OMC_BE_W-1:0] avs_byteenable,
	output logic [omc_pkg::OMC_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic data_cycle,
	input wire logic chopper_clock_in,
	output logic chopper_clock_output,
	output logic wake_transition_indicator_pin,
	output logic [1:0] active_mode,
	output logic in_stop,
	output logic in_standby,
	output logic threshold_compare_enable
);
	import omc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus slave
	logic [OMC_REG_W-1:0] operating_mode_control;
	logic [OMC_REG_W-1:0] next_control;
	logic [OMC_DATA_W-1:0] next_readdata;
	wire req;
	wire hit;
	wire take_write;
	wire first_cycle;

	// decode: one word, low byte lane only, other addresses read zero
	assign req = avs_read || avs_write;
	assign hit = (avs_address == OMC_CTL_ADDR);
	assign first_cycle = req && avs_waitrequest;
	assign take_write = avs_write && !avs_waitrequest && hit &&
		avs_byteenable[0];
	assign next_control = take_write ?
		avs_writedata[OMC_REG_W-1:0] : operating_mode_control;
	assign next_readdata = hit ?
		{{(OMC_DATA_W-OMC_REG_W){1'b0}}, operating_mode_control} :
		OMC_READ_ZERO;

	// waitrequest drops for one cycle after a request is seen
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= OMC_READ_ZERO;
		end else begin
			avs_waitrequest <= !first_cycle;
			if (first_cycle && avs_read) begin
				avs_readdata <= next_readdata;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			operating_mode_control <= OMC_CTL_RESET;
		end else begin
			operating_mode_control <= next_control;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field views
	wire [1:0] mode_field;
	wire [2:0] skip_field;
	wire chop_enable;
	wire wake_enable;
	wire run_enable;
	wire [OMC_CNT_W-1:0] skip_target;

	assign mode_field = operating_mode_control[OMC_MODE_HI:OMC_MODE_LO];
	assign skip_field = operating_mode_control[OMC_SKIP_HI:OMC_SKIP_LO];
	assign chop_enable = operating_mode_control[OMC_CHOP_BIT];
	assign wake_enable = operating_mode_control[OMC_WAKE_BIT];
	assign run_enable = operating_mode_control[OMC_RUN_BIT];
	// skipped cycles are code plus three
	assign skip_target = OMC_SKIP_BASE + {1'b0, skip_field};

	////////////////////////////////////////////////////////////////////////
	// operating state
	omc_state_t state;
	omc_state_t next_state;
	wire was_standby;
	wire will_standby;
	wire will_normal;
	wire standby_entry;
	wire wake_event;
	wire skip_done;

	// stop unless run bit set, else the coded mode
	always_comb begin
		next_state = OMC_ST_STOP;
		if (run_enable) begin
			unique case (mode_field)
				OMC_MODE_NORMAL1: next_state = OMC_ST_NORMAL1;
				OMC_MODE_NORMAL2: next_state = OMC_ST_NORMAL2;
				OMC_MODE_STANDBY1: next_state = OMC_ST_STANDBY1;
				OMC_MODE_STANDBY2: next_state = OMC_ST_STANDBY2;
			endcase
		end
	end

	assign was_standby = (state == OMC_ST_STANDBY1) ||
		(state == OMC_ST_STANDBY2);
	assign will_standby = (next_state == OMC_ST_STANDBY1) ||
		(next_state == OMC_ST_STANDBY2);
	assign will_normal = (next_state == OMC_ST_NORMAL1) ||
		(next_state == OMC_ST_NORMAL2);
	// any change into a standby mode restarts the skip count
	assign standby_entry = will_standby && (next_state != state);
	// standby to normal move, shown only when enabled
	assign wake_event = was_standby && will_normal && wake_enable;

	// state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= OMC_ST_STOP;
		end else begin
			state <= next_state;
		end
	end

	// ignored data cycles counted from standby entry
	omc_skip_counter omc_skip_counter_inst (
		.core_clk(core_clk),
		.reset(reset),
		.restart(standby_entry || !will_standby),
		.data_cycle(data_cycle),
		.target(skip_target),
		.done(skip_done)
	);

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	wire next_chop;
	wire next_compare;

	// chopper clock passes only while enabled
	assign next_chop = chop_enable && chopper_clock_in;
	// compare only in standby after the skipped cycles
	// drops at once on leaving or re-entering standby, no stale pulse
	assign next_compare = will_standby && !standby_entry && skip_done;

	// outputs straight from flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			chopper_clock_output <= 1'b0;
			wake_transition_indicator_pin <= 1'b0;
			active_mode <= OMC_MODE_NORMAL1;
			in_stop <= 1'b1;
			in_standby <= 1'b0;
			threshold_compare_enable <= 1'b0;
		end else begin
			chopper_clock_output <= next_chop;
			wake_transition_indicator_pin <= wake_event;
			active_mode <= mode_field;
			in_stop <= !run_enable;
			in_standby <= will_standby;
			threshold_compare_enable <= next_compare;
		end
	end

endmodule : omc_mode_ctrl

// File: bench/omc_mode_ctrl_asserts.sv
// omc_mode_ctrl_asserts: port checks of the mode control block
// assumes: bound to omc_mode_ctrl, one clock, reset active high
`timescale 1ns/1ps
module omc_mode_ctrl_asserts
	import omc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [omc_pkg::OMC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [omc_pkg::OMC_DATA_W-1:0] avs_writedata,
	input wire logic [omc_pkg::OMC_BE_W-1:0] avs_byteenable,
	input wire logic avs_waitrequest,
	input wire logic chopper_clock_in,
	input wire logic chopper_clock_output,
	input wire logic wake_transition_indicator_pin,
	input wire logic [1:0] active_mode,
	input wire logic in_stop,
	input wire logic in_standby,
	input wire logic threshold_compare_enable
);
	import omc_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// completed write to the control byte, request seen
	sequence s_wr_hit;
		avs_write && !avs_waitrequest && avs_byteenable[0]
			&& avs_address == OMC_CTL_ADDR;
	endsequence
	sequence s_req_seen;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	property p_mode;
		s_wr_hit |-> ##2 active_mode == $past(avs_writedata[7:6], 2);
	endproperty
	property p_stop;
		s_wr_hit |-> ##2 in_stop == !$past(avs_writedata[0], 2);
	endproperty
	property p_sby_code;
		in_standby |-> active_mode[1] && !in_stop;
	endproperty
	property p_restart;
		$rose(in_standby) |=> !threshold_compare_enable [*3];
	endproperty
	property p_cmp_sby;
		threshold_compare_enable |-> in_standby;
	endproperty
	property p_chop;
		chopper_clock_output |-> $past(chopper_clock_in);
	endproperty
	property p_wake;
		wake_transition_indicator_pin |-> !in_standby && !in_stop
			##1 !wake_transition_indicator_pin;
	endproperty
	property p_wait;
		s_req_seen |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_mode: assert property (p_mode) else $error("mode late");
	a_stop: assert property (p_stop) else $error("stop wrong");
	a_sby_code: assert property (p_sby_code) else $error("sby");
	a_restart: assert property (p_restart) else $error("early");
	a_cmp_sby: assert property (p_cmp_sby) else $error("cmp");
	a_chop: assert property (p_chop) else $error("chop");
	a_wake: assert property (p_wake) else $error("wake");
	a_wait: assert property (p_wait) else $error("wait");
endmodule : omc_mode_ctrl_asserts
////////////////////////////////////////////////////////////////////////
bind omc_mode_ctrl omc_mode_ctrl_asserts omc_mode_ctrl_asserts_inst (
	.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .chopper_clock_in(chopper_clock_in),
	.chopper_clock_output(chopper_clock_output),
	.wake_transition_indicator_pin(wake_transition_indicator_pin),
	.active_mode(active_mode), .in_stop(in_stop), .in_standby(in_standby),
	.threshold_compare_enable(threshold_compare_enable));

// File: bench/omc_mode_ctrl_tb.sv
// omc_mode_ctrl_tb: self-checking bench of the mode control register
// assumes: omc_pkg, omc_mode_ctrl and its checker compiled before
`timescale 1ns/1ps
module omc_mode_ctrl_tb;
	import omc_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [OMC_ADDR_W-1:0] a = 8'h00;
	logic rq = 1'b0;
	logic wq = 1'b0;
	logic [OMC_DATA_W-1:0] wd = 32'h00000000;
	logic [OMC_BE_W-1:0] be = 4'h0;
	logic dc = 1'b0;
	logic ci = 1'b0;
	logic [OMC_DATA_W-1:0] rdata, rd;
	logic wt, co, wk, st, sb, ce;
	logic [1:0] am;
	int err_total = 0;
	int n_compared = 0;
	logic [3:0] wake_seen;
	always #10 core_clk = ~core_clk;
	// raw chopper clock, toggling every cycle
	always @(posedge core_clk) ci <= ~ci;
	omc_mode_ctrl omc_mode_ctrl_inst (.core_clk(core_clk), .reset(reset),
		.avs_address(a), .avs_read(rq), .avs_write(wq), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wt),
		.data_cycle(dc), .chopper_clock_in(ci), .chopper_clock_output(co),
		.wake_transition_indicator_pin(wk), .active_mode(am), .in_stop(st),
		.in_standby(sb), .threshold_compare_enable(ce));
	////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest low
	task bus(input logic w, input logic [7:0] ad, d, input logic [3:0] b);
		@(posedge core_clk);
		wq <= w;
		rq <= !w;
		a <= ad;
		wd <= {24'h000000, d};
		be <= b;
		@(posedge core_clk);
		while (wt !== 1'b0) @(posedge core_clk);
		rd = rdata;
		wq <= 1'b0;
		rq <= 1'b0;
	endtask : bus
	task hold;
		repeat (4) @(negedge core_clk);
	endtask : hold
	task wr(input logic [7:0] d);
		bus(1'b1, OMC_CTL_ADDR, d, 4'hF);
		hold;
	endtask : wr
	task pulse(input int n);
		repeat (n) begin
			@(posedge core_clk) dc <= 1'b1;
			@(posedge core_clk) dc <= 1'b0;
		end
		hold;
	endtask : pulse
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		bus(1'b0, OMC_CTL_ADDR, 8'h00, 4'hF);
		chk("reset value", 32'h00000000, rd);
		chk("mode", 2'h0, am);
		chk("stop", 1'b1, st);
		chk("chop", 1'b0, co);
		chk("standby", 1'b0, sb);
	endtask : t_reset
	task t_modes;
		for (int m = 0; m < 4; m++) begin
			wr({m[1:0], 6'h01});
			chk("mode", m, am);
			chk("standby", m[1], sb);
			chk("run", 1'b0, st);
		end
		wr(8'hC0);
		chk("stop", 1'b1, st);
		chk("standby", 1'b0, sb);
	endtask : t_modes
	task t_skip(input logic [2:0] f);
		wr(8'h01);
		wr({2'h2, f, 3'h3});
		pulse(f + 2);
		chk("cmp early", 1'b0, ce);
		pulse(1);
		chk("cmp on", 1'b1, ce);
		wr({2'h3, f, 3'h3});
		chk("cmp restart", 1'b0, ce);
		chk("standby", 1'b1, sb);
		bus(1'b1, OMC_CTL_ADDR, 8'h03, 4'hF);
		wake_seen = 4'h0;
		repeat (6) @(negedge core_clk) wake_seen += wk;
		chk("wake", 1, wake_seen);
	endtask : t_skip
	task t_chop;
		chk("chop off", 1'b0, co);
		wr(8'h04);
		chk("chop on", !ci, co);
		@(negedge core_clk);
		chk("chop on", !ci, co);
	endtask : t_chop
	task t_refuse;
		wr(8'h41);
		bus(1'b1, 8'h2C, 8'hFF, 4'hF);
		bus(1'b1, OMC_CTL_ADDR, 8'hFF, 4'hE);
		bus(1'b0, 8'h2C, 8'h00, 4'hF);
		chk("unmapped", OMC_READ_ZERO, rd);
		bus(1'b0, OMC_CTL_ADDR, 8'h00, 4'hF);
		chk("readback", 32'h00000041, rd);
	endtask : t_refuse
	task t_wake_off;
		wr(8'h81);
		bus(1'b1, OMC_CTL_ADDR, 8'h01, 4'hF);
		wake_seen = 4'h0;
		repeat (6) @(negedge core_clk) wake_seen += wk;
		chk("wake off", 4'h0, wake_seen);
	endtask : t_wake_off
	task t_midreset;
		wr(8'hBD);
		chk("pre reset standby", 1'b1, sb);
		@(posedge core_clk) reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		t_reset;
	endtask : t_midreset
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		t_reset;
		t_modes;
		t_skip(3'h0);
		t_skip(3'h7);
		t_chop;
		t_refuse;
		t_wake_off;
		t_midreset;
		finish_test;
	end
	initial begin
		#100000;
		err_total++;
		finish_test;
	end
endmodule : omc_mode_ctrl_tb
